// >>> rtl/margin_clamp.v
// Margin set point select and upper-limit clamp
`timescale 1ns/1ps
`default_nettype none
`include "pinstrap_defs.vh"
module margin_clamp #(
	parameter W = 12
) (
	input wire [1:0] i_sel, // Margin selection
	input wire [W-1:0] i_nom, // Nominal set point
	input wire [W-1:0] i_high, // High margin limit
	input wire [W-1:0] i_low, // Low margin limit
	output wire [W-1:0] o_target, // Clamped target
	output wire o_clamped // Clamp active
);
	localparam [W+3:0] LIM_NUM = {{(W-10){1'b0}}, `MGN_LIMIT_NUM};
	localparam [W+3:0] LIM_DEN = {{(W-10){1'b0}}, `MGN_LIMIT_DEN};
	wire [W+3:0] cap;
	wire [W-1:0] raw;
	// Low limit may be any value down to zero
	assign raw = (i_sel == `MGN_HIGH) ? i_high : (i_sel == `MGN_LOW) ? i_low : i_nom; // R7
	assign cap = ({4'h0, i_nom} * LIM_NUM) / LIM_DEN;
	assign o_clamped = ({4'h0, raw} > cap); // R8
	assign o_target = o_clamped ? cap[W-1:0] : raw; // R8
endmodule
`default_nettype wire

// >>> rtl/pinstrap_config_decoder.v
// Strap decode of address, phase, tracking and margin, with host override of phase, tracking and margin
// Requirements
// R1: Address strap low 0x20, open 0x21, high reserved
// R2: Resistor bins map to addresses 0x20 to 0x38
// R3: Address values are right-justified, no shift
// R4: Default phase offset is address times 45 degrees
// R5: Host may override phase in 22.5 degree steps
// R6: System syncs all phase-spread converters to one clock
// R7: Margin pin high, low, floating selects set point
// R8: Margins down to zero, clamp at nominal plus ten
// R9: Host sets limits, margin command, transition rate
// R10: Ramp strap gives ratio, limit, fall behaviour
// R11: Tracking ignores strapped delay and ramp settings
// R12: Tracking master needs at least 10 ms delay
// R13: Tracking group enables share one logic source
// R14: Ratiometric tracking defaults to fifty percent
// R15: Tracking enabled by strap or host command
// R16: Alert output accompanies the serial port
// R17: Alert asserts on any enabled fault
// R18: Group is address with low three bits ignored
// R19: Straps sampled once at start, held until override; code re-samples margin pin, delay and ramp straps every cycle
`timescale 1ns/1ps
`default_nettype none
`include "pinstrap_defs.vh"
module pinstrap_config_decoder #(
	parameter W = 12,
	parameter NF = 8,
	parameter RW = 8
) (
	input wire i_ref_clk, // 100 MHz clock
	input wire i_arst_n, // Async reset, active low
	input wire [1:0] i_addr_strap_pin, // Address strap level code
	input wire i_addr_res_fit, // Resistor fitted on address strap
	input wire [4:0] i_addr_res_bin, // Address resistor bin
	input wire [1:0] i_margin_select_pin, // Margin pin level code
	input wire i_track_strap_en, // Config strap selects tracking
	input wire [3:0] i_ramp_res_bin, // Ramp strap bin for tracking
	input wire [W-1:0] i_nom, // Nominal set point from vout straps
	input wire [W-1:0] i_delay_strap, // Strapped soft-start delay
	input wire [W-1:0] i_ramp_strap, // Strapped ramp setting
	input wire i_wr_phase, // Host write phase override
	input wire [3:0] i_wr_phase_code, // Phase code, 22.5 degree units
	input wire i_wr_track, // Host tracking configuration command
	input wire [3:0] i_wr_track_cfg, // {en, ratio50, ref_limit, follow}
	input wire i_wr_mgn, // Host margin configuration write
	input wire [W-1:0] i_wr_mgn_high, // High margin limit
	input wire [W-1:0] i_wr_mgn_low, // Low margin limit
	input wire [RW-1:0] i_wr_mgn_rate, // Margin transition rate
	input wire i_wr_mgn_cmd, // Host margin command write
	input wire [2:0] i_wr_mgn_cmd_val, // {override, sel[1:0]}
	input wire [NF-1:0] i_fault, // Fault conditions
	input wire [NF-1:0] i_fault_en, // Fault enables
	input wire [6:0] i_peer_addr, // Address of a peer event source
	output reg o_ready, // Straps decoded
	output reg [6:0] o_dev_addr, // Device address, right-justified
	output reg o_addr_reserved, // Reserved address strap seen
	output reg [3:0] o_phase_code, // Phase offset in 22.5 degree units
	output reg o_track_en, // Tracking mode active
	output reg o_track_ratio50, // Ratio 50 percent when set
	output reg o_track_ref_limit, // Upper limit is the reference
	output reg o_track_follow, // Output may fall before power good
	output reg [W-1:0] o_delay, // Effective soft-start delay
	output reg [W-1:0] o_ramp, // Effective ramp setting
	output reg [W-1:0] o_target, // Clamped output target
	output reg o_clamped, // Clamp limited the target
	output reg [RW-1:0] o_mgn_rate, // Margin transition rate
	output reg o_fault_alert_out, // Alert, active high
	output wire o_same_group // Peer is in our address group
);
	localparam S_INIT = 3'b001;
	localparam S_SAMP = 3'b010;
	localparam S_RUN = 3'b100;
	localparam SC = `SETTLE_CYC;
	localparam [W-1:0] MGN_DIV = {{(W-5){1'b0}}, `MGN_DEF_DIV};
	reg [2:0] state;
	reg [7:0] cnt;
	reg [W-1:0] mgn_high;
	reg [W-1:0] mgn_low;
	reg mgn_ovr;
	reg [1:0] mgn_sel;
	reg [1:0] pin_sel;
	reg [1:0] next_pin_sel;
	reg [6:0] next_addr;
	wire [1:0] eff_sel;
	wire [W-1:0] tgt;
	wire clamp;
	wire [NF-1:0] fault_hit;
	genvar gi;
	always @*
	begin
		next_addr = `ADDR_BASE;
		if (i_addr_res_fit)
		begin
			if (i_addr_res_bin < `ADDR_BINS)
				next_addr = `ADDR_BASE + {2'h0, i_addr_res_bin}; // R2 R3
		end
		else if (i_addr_strap_pin == `PIN_OPEN)
			next_addr = `ADDR_OPEN; // R1
	end
	// Floating or unused margin pin codes select the nominal point
	always @*
	begin
		case (i_margin_select_pin)
			`PIN_HIGH: next_pin_sel = `MGN_HIGH; // R7
			`PIN_LOW: next_pin_sel = `MGN_LOW; // R7
			default: next_pin_sel = `MGN_NOM; // R7
		endcase
	end
	generate
		for (gi = 0; gi < NF; gi = gi + 1)
		begin : g_fault
			assign fault_hit[gi] = i_fault[gi] & i_fault_en[gi]; // R17
		end
	endgenerate
	always @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			state <= S_INIT;
			cnt <= 8'h00;
			o_ready <= 1'b0;
			o_dev_addr <= `ADDR_BASE;
			o_addr_reserved <= 1'b0;
			o_phase_code <= 4'h0;
			o_track_en <= 1'b0;
			o_track_ratio50 <= 1'b1;
			o_track_ref_limit <= 1'b0;
			o_track_follow <= 1'b0;
			pin_sel <= `MGN_NOM;
			mgn_high <= {W{1'b0}};
			mgn_low <= {W{1'b0}};
			o_mgn_rate <= {RW{1'b0}};
			mgn_ovr <= 1'b0;
			mgn_sel <= `MGN_NOM;
		end
		else
		begin
			case (state)
				S_INIT:
				begin
					cnt <= cnt + 8'h01;
					if (cnt == SC[7:0] - 8'h01)
						state <= S_SAMP;
				end
				S_SAMP:
				begin
					o_dev_addr <= next_addr; // R19
					o_addr_reserved <= !i_addr_res_fit && (i_addr_strap_pin == `PIN_HIGH); // R1
					o_phase_code <= {next_addr[2:0], 1'b0}; // R4
					o_track_en <= i_track_strap_en; // R15
					if (i_ramp_res_bin < `TRK_BINS)
					begin
						o_track_ratio50 <= i_ramp_res_bin[2]; // R10 R14
						o_track_ref_limit <= i_ramp_res_bin[1]; // R10
						o_track_follow <= i_ramp_res_bin[0]; // R10
					end
					mgn_high <= i_nom + (i_nom / MGN_DIV);
					mgn_low <= i_nom - (i_nom / MGN_DIV);
					o_ready <= 1'b1;
					state <= S_RUN;
				end
				// Host writes only land once the straps are decoded
				S_RUN:
				begin
					if (i_wr_phase)
						o_phase_code <= i_wr_phase_code; // R5
					if (i_wr_track)
					begin
						o_track_en <= i_wr_track_cfg[3]; // R15
						o_track_ratio50 <= i_wr_track_cfg[2];
						o_track_ref_limit <= i_wr_track_cfg[1];
						o_track_follow <= i_wr_track_cfg[0];
					end
					if (i_wr_mgn)
					begin
						mgn_high <= i_wr_mgn_high; // R9
						mgn_low <= i_wr_mgn_low; // R9
						o_mgn_rate <= i_wr_mgn_rate; // R9
					end
					if (i_wr_mgn_cmd)
					begin
						mgn_ovr <= i_wr_mgn_cmd_val[2]; // R9
						mgn_sel <= i_wr_mgn_cmd_val[1:0];
					end
				end
				default:
					state <= S_INIT;
			endcase
			pin_sel <= next_pin_sel; // R7
		end
	end
	assign eff_sel = mgn_ovr ? mgn_sel : pin_sel;
	margin_clamp #(
		.W(W)
	) u_clamp (
		.i_sel(eff_sel),
		.i_nom(i_nom),
		.i_high(mgn_high),
		.i_low(mgn_low),
		.o_target(tgt),
		.o_clamped(clamp)
	);
	always @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_delay <= {W{1'b0}};
			o_ramp <= {W{1'b0}};
			o_target <= {W{1'b0}};
			o_clamped <= 1'b0;
			o_fault_alert_out <= 1'b0;
		end
		else
		begin
			o_delay <= o_track_en ? {W{1'b0}} : i_delay_strap; // R11
			o_ramp <= o_track_en ? {W{1'b0}} : i_ramp_strap; // R11
			o_target <= o_ready ? tgt : {W{1'b0}}; // R8
			o_clamped <= o_ready & clamp;
			o_fault_alert_out <= |fault_hit; // R16 R17
		end
	end
	assign o_same_group = ((i_peer_addr ^ o_dev_addr) & `GROUP_MASK) == 7'h00; // R18
endmodule
`default_nettype wire

// >>> rtl/pinstrap_defs.vh
// Constants for the strap decoder
`ifndef PINSTRAP_DEFS_VH
`define PINSTRAP_DEFS_VH
`define PIN_LOW 2'h0
`define PIN_OPEN 2'h1
`define PIN_HIGH 2'h2
`define PIN_RES 2'h3
`define ADDR_BASE 7'h20
`define ADDR_OPEN 7'h21
`define ADDR_BINS 5'h19
`define TRK_BINS 4'h8
`define PHASE_STEP_45 4'h2
`define MGN_NOM 2'h0
`define MGN_HIGH 2'h1
`define MGN_LOW 2'h2
`define MGN_LIMIT_NUM 14'h000B
`define MGN_LIMIT_DEN 14'h000A
`define MGN_DEF_DIV 5'h14
`define GROUP_MASK 7'h78
`define SETTLE_NS 1000
`define CLK_NS 10
`define SETTLE_CYC ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// >>> sim/host_model.sv
// Host model that issues phase override writes
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic i_go, // Request
	input wire logic [3:0] i_code, // Code
	output logic o_wr, // Strobe
	output logic [3:0] o_code // Data
);
assign o_wr = i_go;
// Idle data lines carry the inverted code so a stale code is never taken for a valid one
assign o_code = i_go ? i_code : ~i_code;
endmodule
`default_nettype wire

// >>> sim/pinstrap_config_decoder_assertions.sv
// Checker on the strap decoder ports
`timescale 1ns/1ps
`default_nettype none
module pinstrap_config_decoder_assertions (
	input wire logic i_ref_clk, // Clock
	input wire logic i_arst_n, // Async reset, active low
	input wire logic i_wr_phase, // Phase write strobe
	input wire logic [3:0] i_wr_phase_code, // Phase write code
	input wire logic [7:0] i_fault, // Fault conditions
	input wire logic [7:0] i_fault_en, // Fault enables
	input wire logic o_ready, // Straps decoded
	input wire logic [6:0] o_dev_addr, // Device address
	input wire logic o_addr_reserved, // Reserved strap flag
	input wire logic [3:0] o_phase_code, // Phase code
	input wire logic o_track_en, // Tracking active
	input wire logic [11:0] o_delay, // Effective delay
	input wire logic [11:0] o_ramp, // Effective ramp
	input wire logic o_fault_alert_out // Alert
);
default clocking @(posedge i_ref_clk); endclocking
default disable iff (!i_arst_n);
sequence s_wr;
	o_ready && i_wr_phase;
endsequence
AST_PH: assert property (s_wr |=> o_phase_code == $past(i_wr_phase_code))
	else $error("phase write");
AST_KEEP: assert property (o_ready && !i_wr_phase |=> $stable(o_phase_code))
	else $error("phase moved");
AST_DEF: assert property ($rose(o_ready) |-> o_phase_code == {o_dev_addr[2:0], 1'b0})
	else $error("default phase");
AST_ADDR: assert property (o_ready |-> o_dev_addr inside {[7'h20:7'h38]})
	else $error("address range");
AST_HOLD: assert property (o_ready && $past(o_ready) |-> $stable(o_dev_addr))
	else $error("address moved");
AST_HOLDR: assert property (o_ready && $past(o_ready) |-> $stable(o_addr_reserved))
	else $error("flag moved");
AST_RSV: assert property (o_addr_reserved |-> o_dev_addr == 7'h20)
	else $error("reserved address");
AST_ALRT: assert property (|(i_fault & i_fault_en) |=> o_fault_alert_out)
	else $error("alert missing");
AST_ALRT0: assert property (!(|(i_fault & i_fault_en)) |=> !o_fault_alert_out)
	else $error("alert stuck");
AST_TRK: assert property (o_track_en |=> o_delay == 12'h000 && o_ramp == 12'h000)
	else $error("tracking delay");
endmodule
bind pinstrap_config_decoder pinstrap_config_decoder_assertions i_chk (
	.i_ref_clk(i_ref_clk),
	.i_arst_n(i_arst_n),
	.i_wr_phase(i_wr_phase),
	.i_wr_phase_code(i_wr_phase_code),
	.i_fault(i_fault),
	.i_fault_en(i_fault_en),
	.o_ready(o_ready),
	.o_dev_addr(o_dev_addr),
	.o_addr_reserved(o_addr_reserved),
	.o_phase_code(o_phase_code),
	.o_track_en(o_track_en),
	.o_delay(o_delay),
	.o_ramp(o_ramp),
	.o_fault_alert_out(o_fault_alert_out)
);
`default_nettype wire

// >>> sim/pinstrap_config_decoder_bench.sv
// Self-checking bench for the strap decoder
`timescale 1ns/1ps
`default_nettype none
module pinstrap_config_decoder_bench;
logic i_ref_clk = 0, i_arst_n = 0, go = 0, i_wr_track = 0, i_wr_mgn = 0, i_wr_mgn_cmd = 0;
logic i_addr_res_fit, i_track_strap_en, i_wr_phase, o_ready, o_addr_reserved, o_track_en;
logic o_track_ratio50, o_track_ref_limit, o_track_follow, o_clamped, o_fault_alert_out;
logic o_same_group;
logic [1:0] i_addr_strap_pin, i_margin_select_pin = 0;
logic [2:0] i_wr_mgn_cmd_val = 0;
logic [3:0] i_ramp_res_bin, i_wr_phase_code, o_phase_code, pc = 0, i_wr_track_cfg = 0;
logic [4:0] i_addr_res_bin;
logic [6:0] i_peer_addr, o_dev_addr;
logic [7:0] i_wr_mgn_rate = 0, i_fault = 0, i_fault_en = 0, o_mgn_rate;
logic [11:0] i_nom = 12'h640, i_wr_mgn_high = 0, i_wr_mgn_low = 0;
logic [11:0] i_delay_strap, i_ramp_strap, o_delay, o_ramp, o_target;
logic [31:0] r, e;
integer num_errors = 0, samples_checked = 0, k, n;
pinstrap_config_decoder i_dut (.*);
host_model i_host (.i_go(go), .i_code(pc), .o_wr(i_wr_phase), .o_code(i_wr_phase_code));
initial forever #5 i_ref_clk = ~i_ref_clk;
function automatic [31:0] nx(input [31:0] s);
	nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
task ck(input string nm, input logic [31:0] s, x);
	samples_checked++;
	num_errors += (s !== x);
	if (s !== x)
		$display("MISMATCH %s exp %h seen %h", nm, x, s);
endtask
task test_done;
	$display("%0d checks %0d errors", samples_checked, num_errors);
	if (num_errors == 0 && samples_checked > 0)
		$display("TEST PASSED");
	else
		$display("TEST FAILED");
	$finish;
endtask
task rst;
	i_arst_n = 0;
	repeat (6) @(negedge i_ref_clk);
	i_arst_n = 1;
	for (n = 0; n < 300 && o_ready !== 1'b1; n++)
		@(negedge i_ref_clk);
	ck("rdy", o_ready, 1);
	if (o_ready !== 1'b1)
		test_done;
endtask
initial
begin
	r = 32'h4F7C1495;
	for (k = 0; k < 12; k++)
	begin
		r = nx(r);
		i_addr_strap_pin = (k > 5) ? 2'h0 : 2'(k % 3);
		{i_addr_res_fit, i_track_strap_en} = {k > 5, k[0]};
		i_addr_res_bin = (k == 6) ? 5'h00 : (k == 7) ? 5'h18 : 5'(r % 25);
		{i_ramp_res_bin, i_peer_addr} = {1'b0, r[30:28], 2'h1, r[28:24]};
		{i_delay_strap, i_ramp_strap} = {!k[0], r[22:0]};
		rst;
		@(negedge i_ref_clk);
		e = (k > 5) ? 32'h20 + i_addr_res_bin : (k % 3 == 1) ? 32'h21 : 32'h20;
		ck("addr", o_dev_addr, e);
		ck("rsv", o_addr_reserved, k == 2 || k == 5);
		ck("dph", o_phase_code, e[2:0] * 2);
		ck("grp", o_same_group, i_peer_addr[6:3] == e[6:3]);
		ck("trk", {o_track_en, o_delay, o_ramp}, k[0] ? 25'h1000000 : {2'h1, r[22:0]});
		{go, pc, i_wr_track, i_wr_track_cfg, i_wr_mgn} = {1'b1, r[3:0], 1'b1, r[7:4], 1'b1};
		{i_wr_mgn_high, i_wr_mgn_rate, i_fault, i_fault_en} = {r[19:8] | 12'h600, r[27:20], r[31:16]};
		i_margin_select_pin = 2'(k % 3);
		@(negedge i_ref_clk);
		{go, i_wr_track, i_wr_mgn} = '0;
		ck("ph", o_phase_code, r[3:0]);
		ck("tw", {o_track_en, o_track_ratio50, o_track_ref_limit, o_track_follow}, r[7:4]);
		ck("rate", o_mgn_rate, r[27:20]);
		ck("alrt", o_fault_alert_out, |(r[31:24] & r[23:16]));
		repeat (2) @(negedge i_ref_clk);
		e = (k % 3 == 2) ? ((i_wr_mgn_high > 12'h6E0) ? 12'h6E0 : i_wr_mgn_high) : (k % 3 ? 12'h640 : 0);
		ck("tgt", o_target, e);
		ck("clmp", o_clamped, k % 3 == 2 && i_wr_mgn_high > 12'h6E0);
		{i_wr_mgn_cmd, i_wr_mgn_cmd_val} = {2'h3, 2'((k + 1) % 3)};
		@(negedge i_ref_clk);
		i_wr_mgn_cmd = 0;
		@(negedge i_ref_clk);
		e = (k % 3 == 0) ? ((i_wr_mgn_high > 12'h6E0) ? 12'h6E0 : i_wr_mgn_high) : 0;
		e = (k % 3 == 2) ? 12'h640 : e;
		ck("ovr", o_target, e);
	end
	test_done;
end
endmodule
`default_nettype wire
